//--- logic/bus_csr_defs.vh
`ifndef BUS_CSR_DEFS_VH
`define BUS_CSR_DEFS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFS_SWAP_DATA 8'h0c
`define OFS_SWAP_COMPARE 8'h10
`define OFS_SWAP_CONTROL 8'h14
`define OFS_ROM_HEADER 8'h18
`define OFS_BUS_NAME 8'h1c
`define OFS_BUS_OPTIONS 8'h20

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SWAP_DONE_BIT 31
`define SEL_MSB 1
`define SEL_LSB 0
`define INFO_LEN_MSB 31
`define INFO_LEN_LSB 24
`define CRC_LEN_MSB 23
`define CRC_LEN_LSB 16
`define ROM_CRC_MSB 15
`define ROM_CRC_LSB 0

// ---------------------------------------------------------------
// Resource selector codes
// ---------------------------------------------------------------
`define SEL_BUS_MANAGER_ID 2'h0
`define SEL_BANDWIDTH_AVAIL 2'h1
`define SEL_CHANNELS_HI 2'h2
`define SEL_CHANNELS_LO 2'h3

// ---------------------------------------------------------------
// Reset values and constants
// ---------------------------------------------------------------
`define SWAP_DONE_RESET 1'h1
`define SEL_RESET 2'h0
`define ROM_HEADER_RESET 32'h00000000
`define BUS_NAME_VALUE 32'h31333934
`define BUS_OPTIONS_RESET 32'h0000b003
`define BUS_OPTIONS_WMASK 32'hf8ffffff
`define DATA_RESET 32'h00000000
`define COMPARE_RESET 32'h00000000

`endif

//--- logic/resource_store.v
`timescale 1ns/1ps
`include "bus_csr_defs.vh"

module resource_store #(
  parameter [31:0] INIT0 = 32'h00000000,
  parameter [31:0] INIT1 = 32'h00000000,
  parameter [31:0] INIT2 = 32'h00000000,
  parameter [31:0] INIT3 = 32'h00000000
) (
  input wire clk,
  input wire reset,
  input wire [1:0] rd_index,
  output reg [31:0] rd_data,
  input wire wr_en,
  input wire [1:0] wr_index,
  input wire [31:0] wr_data
);

  reg [31:0] word_reg [0:3];

  // ---------------------------------------------------------------
  // Four bus-management resources
  // ---------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      word_reg[0] <= INIT0;
      word_reg[1] <= INIT1;
      word_reg[2] <= INIT2;
      word_reg[3] <= INIT3;
      rd_data <= 32'h00000000;
    end else begin
      if (wr_en) begin
        word_reg[wr_index] <= wr_data;
      end
      rd_data <= word_reg[rd_index];
    end
  end

endmodule

//--- logic/bus_mgmt_csr.v
`timescale 1ns/1ps
`include "bus_csr_defs.vh"

module bus_mgmt_csr #(
  parameter [31:0] RES_INIT_BUS_MANAGER = 32'h00000000,
  parameter [31:0] RES_INIT_BANDWIDTH = 32'h00000000,
  parameter [31:0] RES_INIT_CHAN_HI = 32'h00000000,
  parameter [31:0] RES_INIT_CHAN_LO = 32'h00000000
) (
  input wire clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  input wire operand_load,
  input wire [31:0] compare_in,
  input wire [31:0] swap_data_in,
  input wire link_on,
  output wire swap_busy,
  output wire [31:0] rom_quadlet0,
  output wire [31:0] bus_info_quadlet0,
  output wire [31:0] bus_info_quadlet1,
  output wire rom_header_unset
);

  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_SWAP = 2'h2;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [31:0] compare_reg;
  reg [31:0] data_reg;
  reg swap_done_flag;
  reg [1:0] resource_select;
  reg [31:0] rom_header_reg;
  reg [31:0] bus_options_reg;
  wire [31:0] res_value;
  wire ctrl_write;
  wire swap_hit;
  wire swap_start;
  wire operand_take;
  wire rom_write;
  wire options_write;
  wire store_write;
  wire [31:0] control_value;
  reg [31:0] read_mux;

  // ---------------------------------------------------------------
  // Address decode and swap qualifiers
  // ---------------------------------------------------------------
  assign ctrl_write = reg_wr && (reg_addr == `OFS_SWAP_CONTROL);
  assign rom_write = reg_wr && (reg_addr == `OFS_ROM_HEADER);
  assign options_write = reg_wr && (reg_addr == `OFS_BUS_OPTIONS);
  // Busy write neither restarts nor retargets the swap
  assign swap_start = ctrl_write && !swap_busy;
  assign operand_take = operand_load && !swap_busy;
  assign swap_busy = (state_reg != ST_IDLE);
  assign swap_hit = (res_value == compare_reg);
  // Write back only on a matching compare
  assign store_write = (state_reg == ST_SWAP) && swap_hit;
  assign control_value = {swap_done_flag, 29'h0, resource_select};

  // ---------------------------------------------------------------
  // Resource storage
  // ---------------------------------------------------------------
  resource_store #(
    .INIT0(RES_INIT_BUS_MANAGER),
    .INIT1(RES_INIT_BANDWIDTH),
    .INIT2(RES_INIT_CHAN_HI),
    .INIT3(RES_INIT_CHAN_LO)
  // Changed only by the swap engine
  ) u_store (
    .clk(clk),
    .reset(reset),
    .rd_index(resource_select),
    .rd_data(res_value),
    .wr_en(store_write),
    .wr_index(resource_select),
    .wr_data(data_reg)
  );

  // ---------------------------------------------------------------
  // Swap sequencer
  // ---------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ctrl_write) begin
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        // Store read data is registered, compare a cycle later
        state_next = ST_SWAP;
      end
      ST_SWAP: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      swap_done_flag <= `SWAP_DONE_RESET;
      resource_select <= `SEL_RESET;
    end else begin
      // Completion wins over a same-cycle clear
      if (state_reg == ST_SWAP) begin
        swap_done_flag <= 1'b1;
      end else if (ctrl_write) begin
        swap_done_flag <= 1'b0;
      end
      if (swap_start) begin
        resource_select <= reg_wdata[`SEL_MSB:`SEL_LSB];
      end
    end
  end

  // ---------------------------------------------------------------
  // Operand registers
  // ---------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      compare_reg <= `COMPARE_RESET;
      data_reg <= `DATA_RESET;
    end else begin
      // Data register hands back the old resource value
      if (state_reg == ST_SWAP) begin
        data_reg <= res_value;
      end else if (operand_take) begin
        compare_reg <= compare_in;
        data_reg <= swap_data_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration ROM header and bus options
  // ---------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rom_header_reg <= `ROM_HEADER_RESET;
      bus_options_reg <= `BUS_OPTIONS_RESET;
    end else begin
      if (rom_write) begin
        rom_header_reg <= reg_wdata;
      end
      // Bits 26:24 of the options stay zero
      if (options_write) begin
        bus_options_reg <= reg_wdata & `BUS_OPTIONS_WMASK;
      end
    end
  end

  assign rom_quadlet0 = rom_header_reg;
  assign bus_info_quadlet0 = `BUS_NAME_VALUE;
  assign bus_info_quadlet1 = bus_options_reg;

  // Either length still zero while the link is on
  assign rom_header_unset = link_on &&
    ((rom_header_reg[`INFO_LEN_MSB:`INFO_LEN_LSB] == 8'h00) ||
     (rom_header_reg[`CRC_LEN_MSB:`CRC_LEN_LSB] == 8'h00));

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always @* begin
    read_mux = 32'h00000000;
    case (reg_addr)
      `OFS_SWAP_DATA: read_mux = data_reg;
      `OFS_SWAP_COMPARE: read_mux = compare_reg;
      `OFS_SWAP_CONTROL: read_mux = control_value;
      `OFS_ROM_HEADER: read_mux = rom_header_reg;
      `OFS_BUS_NAME: read_mux = `BUS_NAME_VALUE;
      `OFS_BUS_OPTIONS: read_mux = bus_options_reg;
      default: read_mux = 32'h00000000;
    endcase
  end

  // Read data held until the next read strobe
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= read_mux;
    end
  end

endmodule

//--- test/bus_mgmt_csr_assertions.sv
`timescale 1ns/1ps
module bus_mgmt_csr_checker (
  input wire clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire link_on,
  input wire swap_busy,
  input wire [31:0] rom_quadlet0,
  input wire [31:0] bus_info_quadlet0,
  input wire [31:0] bus_info_quadlet1,
  input wire rom_header_unset
);
  // ----
  // Swap steps and register checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence start_s; reg_wr && reg_addr == 8'h14 && !swap_busy; endsequence
  sequence ctl_rd_s; reg_rd && !reg_wr && reg_addr == 8'h14; endsequence
  busy_len_a: assert property (start_s |=> swap_busy [*2] ##1 !swap_busy)
    else $error("busy length");
  done_set_a: assert property (start_s ##3 ctl_rd_s |=> reg_rdata[31])
    else $error("done not set");
  done_clr_a: assert property (start_s ##1 ctl_rd_s |=> !reg_rdata[31])
    else $error("done not cleared");
  ctl_rsvd_a: assert property (ctl_rd_s |=> reg_rdata[30:2] == 29'h0)
    else $error("control bits set");
  rom_wr_a: assert property (reg_wr && reg_addr == 8'h18 |=> rom_quadlet0 == $past(reg_wdata))
    else $error("rom write lost");
  rom_unset_a: assert property (rom_header_unset ==
    (link_on && (rom_quadlet0[31:24] == 8'h0 || rom_quadlet0[23:16] == 8'h0))) else $error("unset flag");
  name_const_a: assert property (bus_info_quadlet0 == 32'h31333934)
    else $error("bus name");
  opt_rsvd_a: assert property (bus_info_quadlet1[26:24] == 3'h0)
    else $error("options bits set");
endmodule
bind bus_mgmt_csr bus_mgmt_csr_checker i_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link_on(link_on), .swap_busy(swap_busy),
  .rom_quadlet0(rom_quadlet0), .bus_info_quadlet0(bus_info_quadlet0), .bus_info_quadlet1(bus_info_quadlet1),
  .rom_header_unset(rom_header_unset));

//--- test/bus_mgmt_csr_tb_top.sv
`timescale 1ns/1ps
module bus_mgmt_csr_tb_top;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg [7:0] reg_addr = 8'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [31:0] reg_wdata = 32'h0;
  reg operand_load = 1'b0;
  reg [31:0] compare_in = 32'h0;
  reg [31:0] swap_data_in = 32'h0;
  reg link_on = 1'b0;
  wire swap_busy;
  wire rom_header_unset;
  wire [31:0] reg_rdata, rom_quadlet0, bus_info_quadlet0, bus_info_quadlet1;
  integer err_count = 0;
  integer tests_run = 0;
  integer s;
  bus_mgmt_csr i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .operand_load(operand_load), .compare_in(compare_in),
    .swap_data_in(swap_data_in), .link_on(link_on), .swap_busy(swap_busy), .rom_quadlet0(rom_quadlet0),
    .bus_info_quadlet0(bus_info_quadlet0), .bus_info_quadlet1(bus_info_quadlet1),
    .rom_header_unset(rom_header_unset));
  initial begin
    forever #4 clk = ~clk;
  end
  // ----
  // Access tasks
  // ----
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
      @(posedge clk);
    end
  endtask
  // Loads operands, starts a swap, reads the flag while busy and after
  task swap(input [1:0] sel, input [31:0] c, input [31:0] d);
    begin
      operand_load <= 1'b1;
      compare_in <= c;
      swap_data_in <= d;
      @(posedge clk);
      operand_load <= 1'b0;
      rd(8'h10, c);
      wr(8'h14, 32'h7ffffffc | sel);
      rd(8'h14, {30'h0, sel});
      rd(8'h14, {1'b1, 29'h0, sel});
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #200000;
    err_count = err_count + 1;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    wr(8'h10, 32'hffffffff);
    @(posedge clk);
    wr(8'h1c, 32'h0);
    rd(8'h14, 32'h80000000);
    rd(8'h10, 32'h0);
    rd(8'h1c, 32'h31333934);
    check(bus_info_quadlet0, 32'h31333934);
    rd(8'h18, 32'h0);
    rd(8'h20, 32'h0000b003);
    rd(8'h04, 32'h0);
    for (s = 0; s < 4; s = s + 1) begin
      swap(s[1:0], 32'h0, 32'ha0 + s);
      rd(8'h0c, 32'h0);
      swap(s[1:0], 32'h0, 32'hb0);
      rd(8'h0c, 32'ha0 + s);
      swap(s[1:0], 32'ha0 + s, 32'hc0 + s);
      rd(8'h0c, 32'ha0 + s);
      swap(s[1:0], 32'hc0 + s, 32'hd0 + s);
      rd(8'h0c, 32'hc0 + s);
    end
    // Control write in the compare cycle: completion wins, selector kept
    wr(8'h14, 32'h00000001);
    @(posedge clk);
    wr(8'h14, 32'h00000003);
    rd(8'h14, 32'h80000001);
    rd(8'h0c, 32'h000000d1);
    link_on <= 1'b1;
    wr(8'h18, 32'h0408abcd);
    rd(8'h18, 32'h0408abcd);
    check(rom_quadlet0, 32'h0408abcd);
    check({31'h0, rom_header_unset}, 32'h0);
    wr(8'h18, 32'h0008abcd);
    rd(8'h18, 32'h0008abcd);
    check({31'h0, rom_header_unset}, 32'h1);
    wr(8'h18, 32'h0400abcd);
    rd(8'h18, 32'h0400abcd);
    check({31'h0, rom_header_unset}, 32'h1);
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'hf8ffffff);
    check(bus_info_quadlet1, 32'hf8ffffff);
    // Reset in mid-run restores the registers
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(8'h14, 32'h80000000);
    rd(8'h18, 32'h0);
    check(rom_quadlet0, 32'h0);
    rd(8'h20, 32'h0000b003);
    check({31'h0, rom_header_unset}, 32'h1);
    give_verdict;
  end
endmodule
